// file: src/ucb_uart_ctrl.sv
/*
  Control, status and serial engine of the asynchronous transceiver:
  registers, transmitter, receiver, pin routing and the request line.
  Assumes a plain register port on clk_sys and pins from outside the
  clock domain on the serial input.
*/
`timescale 1ns/1ps
// Overview of operation
// - Stop select one gives two stop bits.
// - Break after buffered data, low fourteen bits.
// - Ninth received bit stored in nine-bit format.
// - Ninth transmitted bit taken from control field.
// - Transmitter off aborts, empties buffer, floats pin.
// - Transmitter active only with both enables.
// - Receiver off aborts, empties buffer, clears overrun.
// - Receiver active only with both enables.
// - Baud rate fH over 64 or 16 times N+1.
// - Free-running eight-bit timer, N from 0-255.
// - Address bit one marks address, raises request.
// - Address bit zero word discarded, no request.
// - Falling edge while clock stopped raises wake.
// - No wake while clock runs or disabled.
// - Receive enable gates ready and overrun flags.
// - Idle enable gates transmitter idle flag.
// - Empty enable gates transmit empty flag.
// - Single-line mode selects shared pin use.
// - Both enables in single-line: pin receives only.
// - Upper seven single-line bits read zero.
// - Shared data register: write sends, read receives.
// - Master off floats pins, clears state, ready and overrun flags; keeps wake.
// - Word length select: eight or nine bits.
// - Least significant bit first, shared rate.
module ucb_uart_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic rxtx_i,
  input wire logic fh_stopped,
  output logic [7:0] rdata_r,
  output logic tx_o_r,
  output logic tx_oe_n_r,
  output logic rxtx_o_r,
  output logic rxtx_oe_n_r,
  output logic irq_r,
  output logic wake_req_r
);

  // Reset release chain and the synchronised copy used everywhere.
  logic rst_s1_r;
  logic rst_n;
  // Serial input synchroniser, and a delayed copy for edge detection.
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_d_r;
  // Software-visible registers.
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;
  logic swm_r;
  logic [7:0] div_r;
  // Transmit holding buffer and its fill state.
  logic [7:0] tx_buf_r;
  logic tx_full_r;
  // Receive buffer, ninth bit and flags.
  logic [7:0] rx_buf_r;
  logic rx_ninth_r;
  logic receive_ready_flag_r;
  logic ovr_r;
  logic wake_r;
  // Set by a status read; arms the clear sequence on a data read.
  logic stat_seen_r;
  // Transmitter engine.
  ucb_pkg::ucb_tx_state_t tx_st_r;
  ucb_pkg::ucb_tx_state_t tx_st_nxt;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic tx_stp_r;
  logic [3:0] brk_cnt_r;
  // Receiver engine.
  ucb_pkg::ucb_rx_state_t rx_st_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_bit_r;
  logic [5:0] rx_cnt_r;

  // Decoded controls.
  logic master_en;
  logic len9;
  logic tx_act;
  logic rx_act;
  logic brk_req;
  logic pre_tick;
  logic bit_tick;
  logic [3:0] last_bit;
  logic [5:0] full_last;
  logic [5:0] half_last;
  logic fall_edge;
  logic tx_line;
  logic single_tx;
  logic transmit_idle_flag;
  logic transmit_empty_flag;

  // Bus decode.
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_single;
  logic wr_data;
  logic wr_div;
  logic rd_data;
  logic rd_stat;
  logic data_accepted;
  logic clr_seq_rd;

  // Frame events.
  logic tx_load;
  logic rx_done;
  logic rx_addr_bit;
  logic rx_keep;
  logic [7:0] rx_word;
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic irq_nxt;
  logic wake_set;

  assign master_en = ctl1_r[ucb_pkg::B_MASTER_EN];
  assign len9 = ctl1_r[ucb_pkg::B_WORD_LEN];
  assign brk_req = ctl1_r[ucb_pkg::B_BREAK];
  assign tx_act = master_en && ctl2_r[ucb_pkg::B_TX_ON];
  assign rx_act = master_en && ctl2_r[ucb_pkg::B_RX_ON];
  assign last_bit = len9 ? ucb_pkg::LAST_BIT_9 : ucb_pkg::LAST_BIT_8;
  assign full_last = ctl2_r[ucb_pkg::B_HIGH_SPEED] ?
                     ucb_pkg::PRE_HIGH_LAST : ucb_pkg::PRE_LOW_LAST;
  assign half_last = ctl2_r[ucb_pkg::B_HIGH_SPEED] ?
                     ucb_pkg::PRE_HIGH_HALF : ucb_pkg::PRE_LOW_HALF;
  assign fall_edge = rx_d_r && !rx_s2_r;

  assign wr_ctl1 = wr_stb && (addr == ucb_pkg::OFS_CTL_ONE);
  assign wr_ctl2 = wr_stb && (addr == ucb_pkg::OFS_CTL_TWO);
  assign wr_single = wr_stb && (addr == ucb_pkg::OFS_SINGLE);
  assign wr_data = wr_stb && (addr == ucb_pkg::OFS_DATA);
  assign wr_div = wr_stb && (addr == ucb_pkg::OFS_DIVISOR);
  assign rd_data = rd_stb && (addr == ucb_pkg::OFS_DATA);
  assign rd_stat = rd_stb && (addr == ucb_pkg::OFS_STATUS);
  // A full holding buffer refuses writes; the byte is then dropped.
  assign data_accepted = wr_data && !tx_full_r;
  assign clr_seq_rd = rd_data && stat_seen_r;

  // Transmit flags: empty while the buffer is free, idle when also
  // nothing is shifting and no break is queued.
  assign transmit_empty_flag = !tx_full_r;
  assign transmit_idle_flag = transmit_empty_flag && (tx_st_r == ucb_pkg::TX_IDLE) && !brk_req;

  // The holding buffer moves to the shifter whenever the line is free.
  assign tx_load = tx_act && bit_tick && tx_full_r &&
                   ((tx_st_r == ucb_pkg::TX_IDLE) ||
                    ((tx_st_r == ucb_pkg::TX_STOP) &&
                     (tx_stp_r || !ctl1_r[ucb_pkg::B_STOP_CNT])));

  // Line level follows the state; data leaves LSB first.
  assign tx_line = (tx_st_r == ucb_pkg::TX_START) ? 1'b0 :
                   (tx_st_r == ucb_pkg::TX_DATA) ? tx_sh_r[0] :
                   (tx_st_r == ucb_pkg::TX_BREAK) ? 1'b0 : 1'b1;

  // Shared pin transmits only in single-line mode without receiver.
  assign single_tx = swm_r && tx_act && !ctl2_r[ucb_pkg::B_RX_ON];

  // Received word alignment depends on the format.
  assign rx_word = len9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_addr_bit = len9 ? rx_sh_r[8] : rx_sh_r[8];
  assign rx_done = rx_act && pre_tick && (rx_st_r == ucb_pkg::RX_STOP) &&
                   (rx_cnt_r >= full_last);
  assign rx_keep = !ctl2_r[ucb_pkg::B_ADDR_DET] || rx_addr_bit;

  assign wake_set = fh_stopped && ctl2_r[ucb_pkg::B_PIN_WAKE] &&
                    fall_edge;

  assign status = {2'b00, wake_r, ovr_r,
                   (rx_st_r == ucb_pkg::RX_IDLE), receive_ready_flag_r, transmit_idle_flag, transmit_empty_flag};

  // Read mux; the transmit ninth bit is write only and reads zero.
  assign rd_mux = (addr == ucb_pkg::OFS_CTL_ONE) ?
                  {ctl1_r[7:2], rx_ninth_r, 1'b0} :
                  (addr == ucb_pkg::OFS_CTL_TWO) ? ctl2_r :
                  (addr == ucb_pkg::OFS_SINGLE) ? {7'h00, swm_r} :
                  (addr == ucb_pkg::OFS_DATA) ? rx_buf_r :
                  (addr == ucb_pkg::OFS_DIVISOR) ? div_r :
                  (addr == ucb_pkg::OFS_STATUS) ? status : 8'h00;

  assign irq_nxt =
    (ctl2_r[ucb_pkg::B_RX_IRQ] && (receive_ready_flag_r || ovr_r)) ||
    (ctl2_r[ucb_pkg::B_TRANSMIT_IDLE_FLAG_IRQ] && transmit_idle_flag) ||
    (ctl2_r[ucb_pkg::B_TEMPTY_IRQ] && transmit_empty_flag) ||
    wake_r;

  ucb_baud_gen #(
    .DIV_W(8)
  ) u_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(!master_en),
    .divisor(div_r),
    .high_speed(ctl2_r[ucb_pkg::B_HIGH_SPEED]),
    .pre_tick(pre_tick),
    .bit_tick(bit_tick)
  );

  // Reset release: asserted at once, released after two clock edges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Serial input passes two flops; the second and its delayed copy are looked at.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else begin
      rx_s1_r <= rxtx_i;
      rx_s2_r <= rx_s1_r;
      rx_d_r <= rx_s2_r;
    end
  end

  // Control registers; a cleared master enable forces off both enables
  // and the break request while keeping the other settings.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_r <= ucb_pkg::RST_CTL_ONE;
      ctl2_r <= ucb_pkg::RST_CTL_TWO;
      swm_r <= 1'b0;
      div_r <= ucb_pkg::RST_DIVISOR;
    end else begin
      if (wr_ctl1) begin
        ctl1_r <= wdata;
      end else if (!master_en) begin
        ctl1_r[ucb_pkg::B_BREAK] <= 1'b0;
      end
      if (wr_ctl2 && master_en) begin
        ctl2_r <= wdata;
      end else if (!master_en) begin
        ctl2_r[ucb_pkg::B_TX_ON] <= 1'b0;
        ctl2_r[ucb_pkg::B_RX_ON] <= 1'b0;
        if (wr_ctl2) begin
          ctl2_r[5:0] <= wdata[5:0];
        end
      end
      if (wr_single) begin
        swm_r <= wdata[0];
      end
      if (wr_div) begin
        div_r <= wdata;
      end
    end
  end

  // Holding buffer: filled by an accepted data write, emptied on load.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_r <= ucb_pkg::RST_DATA;
      tx_full_r <= 1'b0;
    end else if (!tx_act) begin
      tx_full_r <= 1'b0;
    end else if (data_accepted) begin
      tx_buf_r <= wdata;
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // Transmitter next state; every step lands on a baud tick so break
  // and bit lengths are whole bit periods.
  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      ucb_pkg::TX_IDLE: begin
        if (tx_load) begin
          tx_st_nxt = ucb_pkg::TX_START;
        end else if (bit_tick && brk_req) begin
          tx_st_nxt = ucb_pkg::TX_BREAK;
        end
      end
      ucb_pkg::TX_START: begin
        if (bit_tick) begin
          tx_st_nxt = ucb_pkg::TX_DATA;
        end
      end
      ucb_pkg::TX_DATA: begin
        if (bit_tick && (tx_bit_r == last_bit)) begin
          tx_st_nxt = ucb_pkg::TX_STOP;
        end
      end
      ucb_pkg::TX_STOP: begin
        if (tx_load) begin
          tx_st_nxt = ucb_pkg::TX_START;
        end else if (bit_tick &&
                     (tx_stp_r || !ctl1_r[ucb_pkg::B_STOP_CNT])) begin
          tx_st_nxt = ucb_pkg::TX_IDLE;
        end
      end
      ucb_pkg::TX_BREAK: begin
        if (bit_tick && (brk_cnt_r >= ucb_pkg::BREAK_BITS) && !brk_req) begin
          tx_st_nxt = ucb_pkg::TX_IDLE;
        end
      end
      default: begin
        tx_st_nxt = ucb_pkg::TX_IDLE;
      end
    endcase
  end

  // Transmitter datapath; disabling aborts the frame at once.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= ucb_pkg::TX_IDLE;
      tx_sh_r <= '0;
      tx_bit_r <= '0;
      tx_stp_r <= 1'b0;
      brk_cnt_r <= '0;
    end else if (!tx_act) begin
      tx_st_r <= ucb_pkg::TX_IDLE;
      tx_stp_r <= 1'b0;
      brk_cnt_r <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_load) begin
        tx_sh_r <= {ctl1_r[ucb_pkg::B_TX_NINTH], tx_buf_r};
        tx_bit_r <= '0;
        tx_stp_r <= 1'b0;
      end else if (bit_tick && (tx_st_r == ucb_pkg::TX_DATA)) begin
        tx_sh_r <= {1'b0, tx_sh_r[8:1]};
        tx_bit_r <= tx_bit_r + 1'b1;
      end else if (bit_tick && (tx_st_r == ucb_pkg::TX_STOP)) begin
        tx_stp_r <= 1'b1;
      end
      if (tx_st_r != ucb_pkg::TX_BREAK) begin
        brk_cnt_r <= '0;
      end else if (bit_tick && (brk_cnt_r < ucb_pkg::BREAK_BITS)) begin
        brk_cnt_r <= brk_cnt_r + 1'b1;
      end
    end
  end

  // Receiver: start edge, mid-bit check, then one sample per bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= ucb_pkg::RX_IDLE;
      rx_sh_r <= '0;
      rx_bit_r <= '0;
      rx_cnt_r <= '0;
    end else if (!rx_act) begin
      rx_st_r <= ucb_pkg::RX_IDLE;
      rx_cnt_r <= '0;
    end else begin
      case (rx_st_r)
        ucb_pkg::RX_IDLE: begin
          rx_cnt_r <= '0;
          if (fall_edge) begin
            rx_st_r <= ucb_pkg::RX_START;
          end
        end
        ucb_pkg::RX_START: begin
          if (pre_tick && (rx_cnt_r >= half_last)) begin
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            // A start bit that is high again at mid-bit was a glitch.
            rx_st_r <= rx_s2_r ? ucb_pkg::RX_IDLE : ucb_pkg::RX_DATA;
          end else if (pre_tick) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end
        end
        ucb_pkg::RX_DATA: begin
          if (pre_tick && (rx_cnt_r >= full_last)) begin
            rx_cnt_r <= '0;
            rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == last_bit) begin
              rx_st_r <= ucb_pkg::RX_STOP;
            end
          end else if (pre_tick) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end
        end
        ucb_pkg::RX_STOP: begin
          if (rx_done) begin
            rx_st_r <= ucb_pkg::RX_IDLE;
          end else if (pre_tick) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
          end
        end
        default: begin
          rx_st_r <= ucb_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer and flags; a new word beats a same-cycle clear.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_r <= ucb_pkg::RST_DATA;
      rx_ninth_r <= 1'b0;
      receive_ready_flag_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (!rx_act) begin
      receive_ready_flag_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (rx_done && rx_keep && receive_ready_flag_r && !clr_seq_rd) begin
      ovr_r <= 1'b1;
    end else if (rx_done && rx_keep) begin
      rx_buf_r <= rx_word;
      rx_ninth_r <= len9 ? rx_sh_r[8] : rx_ninth_r;
      receive_ready_flag_r <= 1'b1;
      ovr_r <= 1'b0;
    end else if (clr_seq_rd) begin
      receive_ready_flag_r <= 1'b0;
      ovr_r <= 1'b0;
    end
  end

  // Clear-sequence arming, wake flag and the registered outputs.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_seen_r <= 1'b0;
      wake_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      wake_req_r <= 1'b0;
      tx_o_r <= 1'b1;
      tx_oe_n_r <= 1'b1;
      rxtx_o_r <= 1'b1;
      rxtx_oe_n_r <= 1'b1;
    end else begin
      if (rd_stat) begin
        stat_seen_r <= 1'b1;
      end else if (rd_data || wr_data) begin
        stat_seen_r <= 1'b0;
      end
      if (wake_set) begin
        wake_r <= 1'b1;
      end else if (rd_stat) begin
        wake_r <= 1'b0;
      end
      rdata_r <= rd_stb ? rd_mux : 8'h00;
      irq_r <= irq_nxt;
      wake_req_r <= wake_r;
      tx_o_r <= tx_line;
      tx_oe_n_r <= !(tx_act && !single_tx);
      rxtx_o_r <= tx_line;
      rxtx_oe_n_r <= !single_tx;
    end
  end

endmodule

// file: src/ucb_pkg.sv
/*
  Shared constants for the serial control and baud generator block:
  register offsets, field positions, reset values, divider ratios and
  state encodings.
  Assumes it is compiled before every module that names it.
*/
package ucb_pkg;

  // Register offsets on the plain register port (index of an 8-bit reg).
  localparam logic [2:0] OFS_CTL_ONE = 3'h0;
  localparam logic [2:0] OFS_CTL_TWO = 3'h1;
  localparam logic [2:0] OFS_SINGLE = 3'h2;
  localparam logic [2:0] OFS_DATA = 3'h3;
  localparam logic [2:0] OFS_DIVISOR = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;

  // Field positions in serial_control_one.
  localparam int B_MASTER_EN = 7;
  localparam int B_WORD_LEN = 6;
  localparam int B_STOP_CNT = 3;
  localparam int B_BREAK = 2;
  localparam int B_RX_NINTH = 1;
  localparam int B_TX_NINTH = 0;

  // Field positions in serial_control_two.
  localparam int B_TX_ON = 7;
  localparam int B_RX_ON = 6;
  localparam int B_HIGH_SPEED = 5;
  localparam int B_ADDR_DET = 4;
  localparam int B_PIN_WAKE = 3;
  localparam int B_RX_IRQ = 2;
  localparam int B_TRANSMIT_IDLE_FLAG_IRQ = 1;
  localparam int B_TEMPTY_IRQ = 0;

  // Field positions in the status register.
  localparam int B_ST_WAKE = 5;
  localparam int B_ST_OVERRUN = 4;
  localparam int B_ST_RX_IDLE = 3;
  localparam int B_ST_RX_READY = 2;
  localparam int B_ST_TX_IDLE = 1;
  localparam int B_ST_TX_EMPTY = 0;

  // Reset values of the control, divisor and data registers.
  localparam logic [7:0] RST_CTL_ONE = 8'h00;
  localparam logic [7:0] RST_CTL_TWO = 8'h00;
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // Prescale ratios of the baud generator, in divided clock ticks.
  localparam logic [5:0] PRE_LOW_LAST = 6'h3F;
  localparam logic [5:0] PRE_HIGH_LAST = 6'h0F;
  localparam logic [5:0] PRE_LOW_HALF = 6'h1F;
  localparam logic [5:0] PRE_HIGH_HALF = 6'h07;

  // Break length less one in bit periods, and last data bit index per format.
  localparam logic [3:0] BREAK_BITS = 4'hD;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  // Transmitter states.
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP = 3'b011,
    TX_BREAK = 3'b100
  } ucb_tx_state_t;

  // Receiver states.
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ucb_rx_state_t;

endpackage

// file: src/ucb_baud_gen.sv
/*
  Free-running baud generator: an 8-bit reload timer followed by a
  prescaler of 16 or 64.
  Assumes a synchronous reset copy and a clear held while the serial
  function is off.
*/
`timescale 1ns/1ps
module ucb_baud_gen #(
  parameter int DIV_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic high_speed,
  output logic pre_tick,
  output logic bit_tick
);

  // Reload timer: counts down from the divisor, ticking at zero.
  logic [DIV_W-1:0] tmr_r;
  // Prescaler position within one bit period.
  logic [5:0] pre_r;
  // Last prescaler count for the selected speed.
  logic [5:0] pre_last;
  logic tmr_zero;

  assign tmr_zero = (tmr_r == '0);
  assign pre_last = high_speed ? ucb_pkg::PRE_HIGH_LAST :
                    ucb_pkg::PRE_LOW_LAST;
  assign pre_tick = tmr_zero;
  assign bit_tick = tmr_zero && (pre_r >= pre_last);

  // The timer reloads on every terminal count, so the period is N+1.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= '0;
    end else if (clear) begin
      tmr_r <= '0;
    end else if (tmr_zero) begin
      tmr_r <= divisor;
    end else begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // The prescaler uses >= so a speed change mid-period cannot overrun.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (clear) begin
      pre_r <= '0;
    end else if (bit_tick) begin
      pre_r <= '0;
    end else if (tmr_zero) begin
      pre_r <= pre_r + 1'b1;
    end
  end

endmodule

// file: tb/ucb_uart_ctrl_assertions.sv
/*
  Checker for the serial control block, watching its ports only.
  Assumes one clock domain and the asynchronous reset at the ports.
*/
`timescale 1ns/1ps
module ucb_uart_ctrl_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic fh_stopped,
  input wire logic [7:0] rdata_r,
  input wire logic tx_o_r,
  input wire logic tx_oe_n_r,
  input wire logic rxtx_oe_n_r,
  input wire logic irq_r,
  input wire logic wake_req_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Read data stands for one cycle after a read and is zero otherwise.
  rd_quiet_a: assert property (!$past(rd_stb) |-> rdata_r == 8'h00)
    else $error("read data outside a read slot");
  single_upper_a: assert property
    (rd_stb && addr == ucb_pkg::OFS_SINGLE |=> rdata_r[7:1] == 7'h00)
    else $error("single-line upper bits not zero");
  // A running fast clock must never produce a wake request.
  wake_quiet_a: assert property
    (!fh_stopped [*4] |=> !$rose(wake_req_r))
    else $error("wake request while clock runs");
  // The two pins are never driven together.
  one_driver_a: assert property (tx_oe_n_r || rxtx_oe_n_r)
    else $error("both pins driven");
  // The shortest bit lasts sixteen clocks, so a driven level holds.
  bit_hold_a: assert property
    (!tx_oe_n_r && $changed(tx_o_r) |=> ($stable(tx_o_r) || tx_oe_n_r) [*8])
    else $error("bit shorter than eight clocks");
  // With all request enables cleared only a wake may hold the line.
  irq_masked_a: assert property
    (wr_stb && addr == ucb_pkg::OFS_CTL_TWO && wdata[3:0] == 4'h0
     |=> ##1 (!irq_r || wake_req_r))
    else $error("request with enables off");
  tx_idle_high_a: assert property ($fell(tx_oe_n_r) |-> tx_o_r)
    else $error("transmitter not idle high when enabled");
  master_off_a: assert property
    (wr_stb && addr == ucb_pkg::OFS_CTL_ONE && !wdata[7]
     |-> ##[1:3] (tx_oe_n_r && rxtx_oe_n_r))
    else $error("pins still driven after master off");
endmodule

bind ucb_uart_ctrl ucb_uart_ctrl_chk u_chk (.clk_sys(clk_sys),
  .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .fh_stopped(fh_stopped), .rdata_r(rdata_r),
  .tx_o_r(tx_o_r), .tx_oe_n_r(tx_oe_n_r), .rxtx_oe_n_r(rxtx_oe_n_r),
  .irq_r(irq_r), .wake_req_r(wake_req_r));

// file: tb/ucb_remote.sv
/*
  Remote serial device: sends frames on its line and decodes frames
  seen on the block's transmit line.
  Assumes a pulled-up line and a bit length given in clocks.
*/
`timescale 1ns/1ps
module ucb_remote (
  input wire logic clk_sys,
  input wire logic line_i,
  input wire logic [15:0] bitc,
  input wire logic nine,
  output logic line_o
);
  logic [8:0] word_q[$]; // Decoded words, oldest first.
  logic [8:0] w; // Word being decoded.
  int now = 0; // Free clock count.
  int t0 = 0; // Time of the last start bit.
  int gap = 0; // Clocks between the last two start bits.
  initial line_o = 1'b1;
  always @(posedge clk_sys) now <= now + 1;
  // Samples mid-bit, least significant bit first; stop level unchecked.
  always begin
    @(negedge line_i);
    gap = now - t0;
    t0 = now;
    w = 9'h000;
    repeat (bitc / 2) @(posedge clk_sys);
    for (int j = 0; j < (nine ? 9 : 8); j++) begin
      repeat (bitc) @(posedge clk_sys);
      w[j] = line_i;
    end
    repeat (bitc) @(posedge clk_sys);
    word_q.push_back(w);
  end
  // Sends start, data bits and one stop bit.
  task automatic send(input logic [8:0] d);
    for (int j = -1; j < (nine ? 10 : 9); j++) begin
      line_o <= (j < 0) ? 1'b0 : (j >= (nine ? 9 : 8)) ? 1'b1 : d[j];
      repeat (bitc) @(posedge clk_sys);
    end
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Bench: registers, frames both ways, request masks and wake.
  Assumes the design, its package, the checker and the remote model.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic fh_stopped = 1'b0, nine = 1'b0, hs, rem_o, tx_o_r, tx_oe_n_r;
  logic rxtx_o_r, rxtx_oe_n_r, irq_r, wake_req_r;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata_r, v, n;
  logic [8:0] d0, d1;
  logic [15:0] bitc = 16'h0010;
  int num_errors = 0, n_checks = 0, seed = 32'h076CD1A1, k, i;
  // Undriven lines rest high on their pull-ups.
  wire tx_line = tx_oe_n_r ? 1'b1 : tx_o_r;
  wire rx_line = rxtx_oe_n_r ? rem_o : rxtx_o_r;
  ucb_uart_ctrl u_ucb_uart_ctrl (.clk_sys(clk_sys), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rxtx_i(rx_line), .fh_stopped(fh_stopped), .rdata_r(rdata_r),
    .tx_o_r(tx_o_r), .tx_oe_n_r(tx_oe_n_r), .rxtx_o_r(rxtx_o_r),
    .rxtx_oe_n_r(rxtx_oe_n_r), .irq_r(irq_r), .wake_req_r(wake_req_r));
  ucb_remote u_ucb_remote (.clk_sys(clk_sys), .line_i(tx_line),
    .bitc(bitc), .nine(nine), .line_o(rem_o));
  initial forever #4 clk_sys = ~clk_sys;
  // Cuts a hang short well past the longest expected run.
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
  // Bit length in clocks for a speed select and a divisor.
  function automatic logic [15:0] bit_len(input logic h, input logic [7:0] d);
    return (h ? 16'h0010 : 16'h0040) * (16'h0001 + {8'h00, d});
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  // Read data is taken in the one cycle where it stands.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (k = 0; k < 8; k++) begin
      rd(k[2:0], v);
      chk(v, (k == 5) ? 16'h000B : 16'h0000);
    end
    wr(ucb_pkg::OFS_SINGLE, 8'hFF);
    rd(ucb_pkg::OFS_SINGLE, v);
    chk(v, 16'h0001);
    wr(ucb_pkg::OFS_CTL_ONE, 8'h80);
    wr(ucb_pkg::OFS_CTL_TWO, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 chk({tx_oe_n_r, rxtx_oe_n_r, rxtx_o_r}, 3'b101);
    wr(ucb_pkg::OFS_CTL_TWO, 8'hC0);
    repeat (2) @(posedge clk_sys);
    #1 chk(rxtx_oe_n_r, 1'b1);
    wr(ucb_pkg::OFS_SINGLE, 8'h00);
    wr(ucb_pkg::OFS_CTL_ONE, 8'h00);
    wr(ucb_pkg::OFS_CTL_TWO, 8'hFF);
    rd(ucb_pkg::OFS_CTL_TWO, v);
    chk(v, 16'h003F);
    // Frame pairs over word length, stop count and a random baud rate.
    for (k = 0; k < 4; k++) begin
      nine = k[0];
      hs = 1'($random(seed));
      n = 8'($random(seed)) & 8'h03;
      d0 = 9'($random(seed));
      d1 = {d0[8], 8'($random(seed))};
      bitc = bit_len(hs, n);
      wr(ucb_pkg::OFS_DIVISOR, n);
      wr(ucb_pkg::OFS_CTL_ONE, {1'b1, nine, 2'b00, k[1], 2'b00, d0[8]});
      rd(ucb_pkg::OFS_CTL_ONE, v);
      chk(v[0], 1'b0);
      wr(ucb_pkg::OFS_CTL_TWO, {2'b10, hs, 5'h00});
      wr(ucb_pkg::OFS_DATA, d0[7:0]);
      for (i = 0; i < 199; i++) begin
        rd(ucb_pkg::OFS_STATUS, v);
        if (v[0]) break;
      end
      wr(ucb_pkg::OFS_DATA, d1[7:0]);
      for (i = 0; i < 20000 && u_ucb_remote.word_q.size() < 2; i++)
        @(posedge clk_sys);
      chk(u_ucb_remote.word_q.pop_front(), {d0[8] & nine, d0[7:0]});
      chk(u_ucb_remote.word_q.pop_front(), {d1[8] & nine, d1[7:0]});
      chk(16'(u_ucb_remote.gap), (16'h000A + nine + k[1]) * bitc);
    end
    // Break released at once still lasts at least thirteen bits.
    wr(ucb_pkg::OFS_CTL_ONE, 8'h84);
    for (i = 0; i < 9999 && tx_line; i++) @(posedge clk_sys);
    wr(ucb_pkg::OFS_CTL_ONE, 8'h80);
    for (i = 0; i < 20 * bitc && !tx_line; i++) @(posedge clk_sys);
    chk(i >= 13 * bitc - 4, 1'b1);
    chk(tx_line, 1'b1);
    repeat (12 * bitc) @(posedge clk_sys);
    // Transmitter switched off in mid-frame lets the pin float.
    wr(ucb_pkg::OFS_DATA, 8'h5A);
    for (i = 0; i < 9999 && tx_line; i++) @(posedge clk_sys);
    wr(ucb_pkg::OFS_CTL_TWO, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk(tx_oe_n_r, 1'b1);
    for (k = 0; k < 3; k++) begin
      wr(ucb_pkg::OFS_CTL_TWO, {6'h20, k[1:0]});
      repeat (3) @(posedge clk_sys);
      #1 chk(irq_r, k != 0);
    end
    // Receive plain, address-bit-zero and address-bit-one words.
    wr(ucb_pkg::OFS_DIVISOR, 8'h00);
    bitc = 16'h0010;
    for (k = 0; k < 3; k++) begin
      nine = (k != 0);
      d0 = {k == 2, 8'($random(seed))};
      wr(ucb_pkg::OFS_CTL_ONE, {1'b1, nine, 6'h00});
      wr(ucb_pkg::OFS_CTL_TWO, {3'b011, nine, 4'h4});
      u_ucb_remote.send(d0);
      for (i = 0; i < 99 && !irq_r; i++) @(posedge clk_sys);
      chk(irq_r, k != 1);
      if (k != 1) begin
        rd(ucb_pkg::OFS_CTL_ONE, v);
        if (nine) chk(v[1], d0[8]);
        rd(ucb_pkg::OFS_STATUS, v);
        chk(v[2], 1'b1);
        rd(ucb_pkg::OFS_DATA, v);
        chk(v, d0[7:0]);
      end
    end
    // Pin wake only while the fast clock counts as stopped.
    wr(ucb_pkg::OFS_CTL_TWO, 8'h08);
    @(posedge clk_sys) fh_stopped <= 1'b1;
    u_ucb_remote.send(9'h0F0);
    chk(wake_req_r, 1'b1);
    chk(irq_r, 1'b1);
    @(posedge clk_sys) fh_stopped <= 1'b0;
    rd(ucb_pkg::OFS_STATUS, v);
    u_ucb_remote.send(9'h0F0);
    chk(wake_req_r, 1'b0);
    wr(ucb_pkg::OFS_CTL_TWO, 8'hC8);
    wr(ucb_pkg::OFS_CTL_ONE, 8'h00);
    rd(ucb_pkg::OFS_CTL_TWO, v);
    chk(v, 16'h0008);
    conclude();
  end
endmodule
